/* rtl/counter_array_pwm_10_16bit.v */
// Functional notes
// - 16-bit mode: output high while counter is at or above compare value.
// - 16-bit mode: counter overflow drives module outputs low, except those with compare value zero.
// - 16-bit period set only by counter clock, full range each period.
// - 10-bit mode: counter halves form one 10-bit counter, compare 10-bit.
// - 10-bit mode: high at or above compare, low on 10-bit overflow unless the low ten compare bits are zero.
// - 10-bit mode ignores upper six bits of counter high and compare high.
// - low compare write clears compare enable; high compare write sets it.
// - compare zero gives full duty; all ones gives shortest high time.
// - compare enable cleared keeps the output low.
// - global enable in first control runs both counters while set; clearing stops those with run bit zero.
// - each counter counts only while its run bit or the global enable is one.
// - overflow interrupt enable requests interrupt while overflow flag is set.
// - idle-stop set halts counter in processor idle; clear keeps running.
// - width-select bit: zero 16-bit, one 10-bit modulation.
// - clock source: 00 prescaler, 01 timer 0 overflow, 10 external pin.
// - shared status: block 1 flags upper nibble, block 0 lower nibble.
// - each block has a control register, each module a mode register.
// - mode field 11 selects wide fixed-frequency modulation and enables the pin.
// - hardware or software sets overflow flag; only software clears it.
// - six module flags and two overflow flags ORed into one interrupt.
`timescale 1ns/1ps
`include "counter_array_pwm_defines.vh"

module counter_array_pwm_10_16bit #(
  parameter BLOCKS = 2,
  parameter MODULES_PER_BLOCK = 3,
  parameter COUNTER_BITS = 16,
  parameter NARROW_BITS = 10
) (
  input wire ref_clk,
  input wire reset,
  input wire [7:0] sfr_addr,
  input wire [7:0] sfr_wdata,
  input wire sfr_wr,
  input wire sfr_rd,
  output reg [7:0] sfr_rdata,
  input wire cpu_idle,
  input wire [1:0] prescaler_tick,
  input wire timer0_overflow,
  input wire [1:0] external_clock_pin,
  output wire [5:0] module_output_pin,
  output wire [5:0] module_output_enable,
  output wire counter_irq
);

  localparam MODULES = BLOCKS * MODULES_PER_BLOCK;

  reg [7:0] first_block_control_reg;
  reg [7:0] second_block_control_reg;
  reg [7:0] shared_counter_status_reg;
  reg [7:0] shared_counter_status_next;
  reg [1:0] ext_sync1_reg;
  reg [1:0] ext_sync2_reg;
  reg [1:0] ext_last_reg;
  reg [7:0] read_mux;
  wire [15:0] control_flat;
  wire [8*MODULES-1:0] mode_flat;
  wire [8*MODULES-1:0] compare_low_flat;
  wire [8*MODULES-1:0] compare_high_flat;
  wire [COUNTER_BITS*BLOCKS-1:0] count_flat;
  wire [COUNTER_BITS*BLOCKS-1:0] count_next_flat;
  wire [BLOCKS-1:0] overflow;
  wire [BLOCKS-1:0] block_tick;
  wire [MODULES-1:0] match_event;
  wire [MODULES-1:0] module_irq;
  wire [1:0] ext_edge;
  wire [7:0] status_hw_set;
  wire wr_first_control;
  wire wr_second_control;
  wire wr_status;
  wire global_enable;
  wire [2:0] module_sel;

  assign control_flat = {second_block_control_reg, first_block_control_reg};
  assign global_enable = first_block_control_reg[`CTRL_GLOBAL_ENABLE];
  assign module_sel = sfr_addr[2:0];

  // write strobes for the fixed registers
  assign wr_first_control = sfr_wr & (sfr_addr == `FIRST_BLOCK_CONTROL_ADDR);
  assign wr_second_control = sfr_wr & (sfr_addr == `SECOND_BLOCK_CONTROL_ADDR);
  assign wr_status = sfr_wr & (sfr_addr == `SHARED_COUNTER_STATUS_ADDR);

  // external clock pins: two-stage synchroniser, then an edge stage
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      ext_sync1_reg <= 2'b00;
      ext_sync2_reg <= 2'b00;
      ext_last_reg <= 2'b00;
    end else begin
      ext_sync1_reg <= external_clock_pin;
      ext_sync2_reg <= ext_sync1_reg;
      ext_last_reg <= ext_sync2_reg;
    end
  end

  assign ext_edge = ext_sync2_reg & ~ext_last_reg;

  // per-block control registers
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      first_block_control_reg <= `CONTROL_RESET;
      second_block_control_reg <= `CONTROL_RESET;
    end else begin
      if (wr_first_control) begin
        first_block_control_reg <= sfr_wdata & `FIRST_CONTROL_WMASK;
      end
      if (wr_second_control) begin
        second_block_control_reg <= sfr_wdata & `SECOND_CONTROL_WMASK;
      end
    end
  end

  // counter blocks with clock source, run and idle gating
  genvar m;
  generate
    for (m = 0; m < BLOCKS; m = m + 1) begin : blk
      wire [7:0] ctrl;
      wire [1:0] src;
      wire source_tick;
      wire running;
      wire load_low;
      wire load_high;
      wire [COUNTER_BITS-1:0] count_value;
      wire [COUNTER_BITS-1:0] count_next;
      // address sums are integers; only their low byte is kept
      localparam integer LOW_SUM = `COUNTER_BASE_ADDR + 2 * m;
      localparam integer HIGH_SUM = `COUNTER_BASE_ADDR + 2 * m + 1;
      localparam [7:0] LOW_ADDR = LOW_SUM[7:0];
      localparam [7:0] HIGH_ADDR = HIGH_SUM[7:0];

      assign ctrl = control_flat[8*m+:8];
      assign src = ctrl[`CTRL_CLOCK_SOURCE_LSB+:2];
      assign source_tick = (src == `CLOCK_SOURCE_PRESCALER) ? prescaler_tick[m] :
                           (src == `CLOCK_SOURCE_TIMER0) ? timer0_overflow :
                           (src == `CLOCK_SOURCE_EXTERNAL) ? ext_edge[m] : 1'b0;
      assign running = (ctrl[`CTRL_COUNTER_RUN] | global_enable)
                       & ~(ctrl[`CTRL_IDLE_STOP] & cpu_idle);
      assign block_tick[m] = running & source_tick;
      assign load_low = sfr_wr & (sfr_addr == LOW_ADDR);
      assign load_high = sfr_wr & (sfr_addr == HIGH_ADDR);

      block_counter #(
        .WIDE_BITS(COUNTER_BITS),
        .NARROW_BITS(NARROW_BITS)
      ) counter_inst (
        .ref_clk(ref_clk),
        .reset(reset),
        .count_tick(block_tick[m]),
        .width_select(ctrl[`CTRL_WIDTH_SELECT]),
        .load_low(load_low),
        .load_high(load_high),
        .load_data(sfr_wdata),
        .count_reg(count_value),
        .count_next(count_next),
        .overflow_pulse(overflow[m])
      );

      assign count_flat[COUNTER_BITS*m+:COUNTER_BITS] = count_value;
      assign count_next_flat[COUNTER_BITS*m+:COUNTER_BITS] = count_next;
    end
  endgenerate

  // timer/compare modules: mode, compare pair and modulated output
  genvar g;
  generate
    for (g = 0; g < MODULES; g = g + 1) begin : timer_compare_module
      localparam BLK = g / MODULES_PER_BLOCK;
      // address sums are integers; only their low byte is kept
      localparam integer MODE_SUM = `MODE_BASE_ADDR + g;
      localparam integer LOW_SUM = `COMPARE_LOW_BASE_ADDR + g;
      localparam integer HIGH_SUM = `COMPARE_HIGH_BASE_ADDR + g;
      localparam [7:0] MODE_ADDR = MODE_SUM[7:0];
      localparam [7:0] LOW_ADDR = LOW_SUM[7:0];
      localparam [7:0] HIGH_ADDR = HIGH_SUM[7:0];
      reg [7:0] mode_reg;
      reg [7:0] compare_low_reg;
      reg [7:0] compare_high_reg;
      reg out_reg;
      wire narrow;
      wire pwm_wide;
      wire compare_on;
      wire [COUNTER_BITS-1:0] cnt_next;
      wire [COUNTER_BITS-1:0] compare_value;
      wire at_or_above;
      wire equal;

      assign narrow = control_flat[8*BLK+`CTRL_WIDTH_SELECT];
      assign pwm_wide = (mode_reg[`MODE_PWM_LSB+:2] == `MODE_PWM_WIDE);
      assign compare_on = mode_reg[`MODE_COMPARE_ENABLE];
      assign cnt_next = count_next_flat[COUNTER_BITS*BLK+:COUNTER_BITS];
      assign compare_value = {compare_high_reg, compare_low_reg};
      // narrow compare looks only at the low ten bits of both sides
      assign at_or_above = narrow ?
        (cnt_next[NARROW_BITS-1:0] >= compare_value[NARROW_BITS-1:0]) :
        (cnt_next >= compare_value);
      assign equal = narrow ?
        (cnt_next[NARROW_BITS-1:0] == compare_value[NARROW_BITS-1:0]) :
        (cnt_next == compare_value);
      assign match_event[g] = block_tick[BLK] & compare_on & mode_reg[`MODE_MATCH_FLAG] & equal;
      assign module_irq[g] = mode_reg[`MODE_EVENT_IRQ_ENABLE];

      // mode and compare registers; compare writes steer the compare enable
      always @(posedge ref_clk or posedge reset) begin
        if (reset) begin
          mode_reg <= `MODE_RESET;
          compare_low_reg <= `COMPARE_RESET;
          compare_high_reg <= `COMPARE_RESET;
        end else begin
          if (sfr_wr & (sfr_addr == MODE_ADDR)) begin
            mode_reg <= sfr_wdata;
          end else if (sfr_wr & (sfr_addr == LOW_ADDR)) begin
            mode_reg[`MODE_COMPARE_ENABLE] <= 1'b0;
          end else if (sfr_wr & (sfr_addr == HIGH_ADDR)) begin
            mode_reg[`MODE_COMPARE_ENABLE] <= 1'b1;
          end
          if (sfr_wr & (sfr_addr == LOW_ADDR)) begin
            compare_low_reg <= sfr_wdata;
          end
          if (sfr_wr & (sfr_addr == HIGH_ADDR)) begin
            compare_high_reg <= sfr_wdata;
          end
        end
      end

      // output follows the counter value loaded at the same edge, so a wrap
      // to zero drops it unless the compare value is zero
      always @(posedge ref_clk or posedge reset) begin
        if (reset) begin
          out_reg <= 1'b0;
        end else begin
          out_reg <= pwm_wide & compare_on & at_or_above;
        end
      end

      assign module_output_pin[g] = out_reg;
      assign module_output_enable[g] = pwm_wide;
      assign mode_flat[8*g+:8] = mode_reg;
      assign compare_low_flat[8*g+:8] = compare_low_reg;
      assign compare_high_flat[8*g+:8] = compare_high_reg;
    end
  endgenerate

  // shared status: hardware set wins over a software write in the same cycle
  assign status_hw_set = {overflow[1], match_event[5:3], overflow[0], match_event[2:0]};

  always @* begin
    if (wr_status) begin
      shared_counter_status_next = sfr_wdata | status_hw_set;
    end else begin
      shared_counter_status_next = shared_counter_status_reg | status_hw_set;
    end
  end

  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      shared_counter_status_reg <= `STATUS_RESET;
    end else begin
      shared_counter_status_reg <= shared_counter_status_next;
    end
  end

  // one combined interrupt request
  assign counter_irq =
    (shared_counter_status_reg[`STATUS_FIRST_OVERFLOW] &
     first_block_control_reg[`CTRL_OVERFLOW_IRQ_ENABLE]) |
    (shared_counter_status_reg[`STATUS_SECOND_OVERFLOW] &
     second_block_control_reg[`CTRL_OVERFLOW_IRQ_ENABLE]) |
    (|({shared_counter_status_reg[6:4], shared_counter_status_reg[2:0]} & module_irq));

  // read decode
  always @* begin
    if (sfr_addr == `FIRST_BLOCK_CONTROL_ADDR) begin
      read_mux = first_block_control_reg;
    end else if (sfr_addr == `SECOND_BLOCK_CONTROL_ADDR) begin
      read_mux = second_block_control_reg;
    end else if (sfr_addr == `SHARED_COUNTER_STATUS_ADDR) begin
      read_mux = shared_counter_status_reg;
    end else if ((sfr_addr[7:3] == `MODE_BASE_ADDR >> 3) && (module_sel < 3'd6)) begin
      read_mux = mode_flat[8*module_sel+:8];
    end else if ((sfr_addr[7:3] == `COMPARE_LOW_BASE_ADDR >> 3) && (module_sel < 3'd6)) begin
      read_mux = compare_low_flat[8*module_sel+:8];
    end else if ((sfr_addr[7:3] == `COMPARE_HIGH_BASE_ADDR >> 3) && (module_sel < 3'd6)) begin
      read_mux = compare_high_flat[8*module_sel+:8];
    end else if (sfr_addr[7:2] == `COUNTER_BASE_ADDR >> 2) begin
      read_mux = count_flat[8*sfr_addr[1:0]+:8];
    end else begin
      read_mux = 8'h00;
    end
  end

  // read data register
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      sfr_rdata <= 8'h00;
    end else if (sfr_rd) begin
      sfr_rdata <= read_mux;
    end
  end

endmodule

/* rtl/counter_array_pwm_defines.vh */
`ifndef COUNTER_ARRAY_PWM_DEFINES_VH
`define COUNTER_ARRAY_PWM_DEFINES_VH

// special function register addresses
`define FIRST_BLOCK_CONTROL_ADDR 8'ha4
`define SHARED_COUNTER_STATUS_ADDR 8'ha5
`define SECOND_BLOCK_CONTROL_ADDR 8'hbc
`define MODE_BASE_ADDR 8'hc0
`define COMPARE_LOW_BASE_ADDR 8'hd0
`define COMPARE_HIGH_BASE_ADDR 8'hd8
`define COUNTER_BASE_ADDR 8'he0

// reset values
`define CONTROL_RESET 8'h00
`define STATUS_RESET 8'h00
`define MODE_RESET 8'h00
`define COMPARE_RESET 8'h00

// writable bits of the control registers (bit 3 reserved, bit 7 only in block 0)
`define FIRST_CONTROL_WMASK 8'hf7
`define SECOND_CONTROL_WMASK 8'h77

// control register fields
`define CTRL_GLOBAL_ENABLE 7
`define CTRL_COUNTER_RUN 6
`define CTRL_OVERFLOW_IRQ_ENABLE 5
`define CTRL_IDLE_STOP 4
`define CTRL_WIDTH_SELECT 2
`define CTRL_CLOCK_SOURCE_LSB 0

// clock source encodings
`define CLOCK_SOURCE_PRESCALER 2'b00
`define CLOCK_SOURCE_TIMER0 2'b01
`define CLOCK_SOURCE_EXTERNAL 2'b10

// module mode register fields
`define MODE_EVENT_IRQ_ENABLE 7
`define MODE_COMPARE_ENABLE 6
`define MODE_MATCH_FLAG 3
`define MODE_PWM_LSB 0
`define MODE_PWM_WIDE 2'b11

// shared status register bit positions
`define STATUS_FIRST_OVERFLOW 3
`define STATUS_SECOND_OVERFLOW 7

`endif

/* rtl/block_counter.v */
`timescale 1ns/1ps
`include "counter_array_pwm_defines.vh"

module block_counter #(
  parameter WIDE_BITS = 16,
  parameter NARROW_BITS = 10
) (
  input wire ref_clk,
  input wire reset,
  input wire count_tick,
  input wire width_select,
  input wire load_low,
  input wire load_high,
  input wire [7:0] load_data,
  output reg [WIDE_BITS-1:0] count_reg,
  output reg [WIDE_BITS-1:0] count_next,
  output wire overflow_pulse
);

  wire at_max;
  wire [NARROW_BITS-1:0] narrow_inc;
  wire [WIDE_BITS-1:0] wide_inc;

  // wrap point follows the selected width; upper six bits idle in narrow mode
  assign at_max = width_select ? (&count_reg[NARROW_BITS-1:0]) : (&count_reg);
  assign narrow_inc = count_reg[NARROW_BITS-1:0] + {{(NARROW_BITS-1){1'b0}}, 1'b1};
  assign wide_inc = count_reg + {{(WIDE_BITS-1){1'b0}}, 1'b1};
  assign overflow_pulse = count_tick & at_max & ~load_low & ~load_high;

  // software loads win over a count tick in the same cycle
  always @* begin
    if (load_low) begin
      count_next = {count_reg[WIDE_BITS-1:8], load_data};
    end else if (load_high) begin
      count_next = {load_data, count_reg[7:0]};
    end else if (count_tick) begin
      if (width_select) begin
        count_next = {count_reg[WIDE_BITS-1:NARROW_BITS], narrow_inc};
      end else begin
        count_next = wide_inc;
      end
    end else begin
      count_next = count_reg;
    end
  end

  // counter state
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      count_reg <= {WIDE_BITS{1'b0}};
    end else begin
      count_reg <= count_next;
    end
  end

endmodule

/* tb/counter_array_pwm_checker_sva.sv */
`timescale 1ns/1ps
module counter_array_pwm_checker (
  input wire ref_clk,
  input wire reset,
  input wire [7:0] sfr_addr,
  input wire [7:0] sfr_wdata,
  input wire sfr_wr,
  input wire sfr_rd,
  input wire [7:0] sfr_rdata,
  input wire cpu_idle,
  input wire [1:0] prescaler_tick,
  input wire timer0_overflow,
  input wire [1:0] external_clock_pin,
  input wire [5:0] module_output_pin,
  input wire [5:0] module_output_enable,
  input wire counter_irq
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  // register bus answers
  a_unmapped_read_zero: assert property (sfr_rd && sfr_addr < 8'ha4 |=> sfr_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_reserved_bits_zero: assert property (sfr_rd && sfr_addr == 8'hbc |=> !sfr_rdata[7] && !sfr_rdata[3])
    else $error("reserved control bits read back set");
  a_ctrl_write_readback: assert property (sfr_wr && sfr_addr == 8'ha4 ##1 !sfr_wr ##1 sfr_rd && sfr_addr == 8'ha4
    |=> sfr_rdata == ($past(sfr_wdata, 3) & 8'hf7))
    else $error("first control read back differs");
  a_rdata_holds: assert property (!sfr_rd |=> $stable(sfr_rdata))
    else $error("read data moved without a read");
  // output pins against mode and compare enable
  a_mode_sets_enable: assert property (sfr_wr && sfr_addr == 8'hc0
    |=> module_output_enable[0] == ($past(sfr_wdata[1:0]) == 2'b11))
    else $error("output enable does not follow mode field");
  a_low_write_kills: assert property (sfr_wr && sfr_addr == 8'hd0 |-> ##[1:2] !module_output_pin[0])
    else $error("pin high after low compare write");
  a_pin_needs_mode: assert property ((module_output_enable == 6'h00) [*2] |-> module_output_pin == 6'h00)
    else $error("pin high without modulation mode");
  a_irq_cleared: assert property (sfr_wr && sfr_addr == 8'ha5 && sfr_wdata == 8'h00 && prescaler_tick == 2'b00
    && !timer0_overflow && external_clock_pin == 2'b00 && $past(external_clock_pin, 1) == 2'b00
    && $past(external_clock_pin, 2) == 2'b00 && $past(external_clock_pin, 3) == 2'b00 |=> !counter_irq)
    else $error("interrupt stays after status clear");
  c_pin0_rise: cover property ($rose(module_output_pin[0]));
  c_pin3_rise: cover property ($rose(module_output_pin[3]));
  c_irq_rise: cover property ($rose(counter_irq));
endmodule

/* tb/cpu_model.sv */
`timescale 1ns/1ps
module cpu_model (
  input wire ref_clk,
  output logic [7:0] sfr_addr,
  output logic [7:0] sfr_wdata,
  output logic sfr_wr,
  output logic sfr_rd,
  input wire [7:0] sfr_rdata
);
  // bus quiet at time zero
  initial begin
    sfr_addr = 8'h00;
    sfr_wdata = 8'h00;
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
  end
  // one-cycle write; idle address and data show the inverse so stale values are never trusted
  task sfr_write(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge ref_clk);
    sfr_wr = 1'b0;
    sfr_addr = ~a;
    sfr_wdata = ~d;
  endtask
  // one-cycle read; registered data is taken after the strobe edge
  task sfr_read(input logic [7:0] a, output logic [7:0] d);
    @(negedge ref_clk);
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(negedge ref_clk);
    sfr_rd = 1'b0;
    sfr_addr = ~a;
    d = sfr_rdata;
  endtask
  // full compare value, low byte always first
  task load_compare(input logic [2:0] n, input logic [15:0] v);
    sfr_write(8'hd0 + {5'h00, n}, v[7:0]);
    sfr_write(8'hd8 + {5'h00, n}, v[15:8]);
  endtask
endmodule

/* tb/testbench.sv */
`timescale 1ns/1ps
module testbench;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic cpu_idle = 1'b0;
  logic [1:0] prescaler_tick = 2'b00;
  logic timer0_overflow = 1'b0;
  logic [1:0] external_clock_pin = 2'b00;
  wire [7:0] sfr_addr;
  wire [7:0] sfr_wdata;
  wire [7:0] sfr_rdata;
  wire sfr_wr;
  wire sfr_rd;
  wire [5:0] module_output_pin;
  wire [5:0] module_output_enable;
  wire counter_irq;
  int mismatches = 0;
  int tests_run = 0;
  logic [7:0] rd;
  always #20 ref_clk = ~ref_clk;
  cpu_model i_cpu_model (.ref_clk(ref_clk), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata));
  counter_array_pwm_10_16bit i_counter_array_pwm_10_16bit (.ref_clk(ref_clk), .reset(reset),
    .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
    .cpu_idle(cpu_idle), .prescaler_tick(prescaler_tick), .timer0_overflow(timer0_overflow),
    .external_clock_pin(external_clock_pin), .module_output_pin(module_output_pin),
    .module_output_enable(module_output_enable), .counter_irq(counter_irq));
  // compare and count
  task check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task rd_chk(input logic [7:0] a, input logic [7:0] exp);
    i_cpu_model.sfr_read(a, rd);
    check(rd, exp);
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    i_cpu_model.sfr_write(a, d);
  endtask
  // prescaler pulses, one cycle each, with a gap between
  task tick(input logic [1:0] m, input int n);
    repeat (n) begin
      @(negedge ref_clk);
      prescaler_tick = m;
      @(negedge ref_clk);
      prescaler_tick = 2'b00;
    end
  endtask
  task print_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // cuts a hang short
  initial begin
    repeat (20000) @(posedge ref_clk);
    mismatches++;
    print_verdict;
  end
  initial begin
    repeat (20) @(posedge ref_clk);
    @(negedge ref_clk) reset = 1'b0;
    rd_chk(8'ha4, 8'h00);
    rd_chk(8'ha5, 8'h00);
    rd_chk(8'hbc, 8'h00);
    rd_chk(8'h10, 8'h00);
    wr(8'ha4, 8'hff);
    rd_chk(8'ha4, 8'hf7);
    wr(8'hbc, 8'hff);
    rd_chk(8'hbc, 8'h77);
    wr(8'ha4, 8'h00);
    wr(8'hbc, 8'h00);
    $display("registers done");
    for (int n = 0; n < 3; n++) wr(8'hc0 + n[7:0], 8'hc3);
    check({2'b00, module_output_enable}, 8'h07);
    wr(8'hd0, 8'h02);
    rd_chk(8'hc0, 8'h83);
    wr(8'hd8, 8'h00);
    rd_chk(8'hc0, 8'hc3);
    i_cpu_model.load_compare(3'd1, 16'h0000);
    wr(8'hd2, 8'h00);
    wr(8'he0, 8'hfe);
    wr(8'he1, 8'hff);
    wr(8'ha4, 8'h40);
    tick(2'b01, 1);
    check({5'h00, module_output_pin[2:0]}, 8'h03);
    tick(2'b01, 1);
    check({5'h00, module_output_pin[2:0]}, 8'h02);
    rd_chk(8'ha5, 8'h08);
    check({7'h00, counter_irq}, 8'h00);
    tick(2'b01, 1);
    check({5'h00, module_output_pin[2:0]}, 8'h02);
    tick(2'b01, 1);
    check({5'h00, module_output_pin[2:0]}, 8'h03);
    wr(8'ha4, 8'h60);
    check({7'h00, counter_irq}, 8'h01);
    wr(8'ha5, 8'h00);
    check({7'h00, counter_irq}, 8'h00);
    wr(8'ha5, 8'h80);
    rd_chk(8'ha5, 8'h80);
    wr(8'ha5, 8'h00);
    $display("16-bit modulation done");
    i_cpu_model.load_compare(3'd0, 16'hffff);
    wr(8'he0, 8'hfe);
    wr(8'he1, 8'hff);
    tick(2'b01, 1);
    check({5'h00, module_output_pin[2:0]}, 8'h03);
    tick(2'b01, 1);
    check({5'h00, module_output_pin[2:0]}, 8'h02);
    wr(8'ha4, 8'h00);
    tick(2'b01, 1);
    rd_chk(8'he0, 8'h00);
    wr(8'ha4, 8'h50);
    cpu_idle = 1'b1;
    tick(2'b01, 1);
    rd_chk(8'he0, 8'h00);
    wr(8'ha4, 8'h40);
    tick(2'b01, 1);
    rd_chk(8'he0, 8'h01);
    cpu_idle = 1'b0;
    wr(8'ha4, 8'h80);
    tick(2'b11, 1);
    rd_chk(8'he0, 8'h02);
    rd_chk(8'he2, 8'h01);
    wr(8'ha4, 8'h00);
    tick(2'b11, 1);
    rd_chk(8'he0, 8'h02);
    wr(8'ha4, 8'h41);
    @(negedge ref_clk) timer0_overflow = 1'b1;
    @(negedge ref_clk) timer0_overflow = 1'b0;
    tick(2'b01, 1);
    rd_chk(8'he0, 8'h03);
    wr(8'ha4, 8'h42);
    @(negedge ref_clk) external_clock_pin = 2'b01;
    repeat (4) @(negedge ref_clk);
    external_clock_pin = 2'b00;
    repeat (4) @(negedge ref_clk);
    rd_chk(8'he0, 8'h04);
    wr(8'ha4, 8'h00);
    wr(8'ha5, 8'h00);
    $display("counter control done");
    for (int n = 3; n < 6; n++) wr(8'hc0 + n[7:0], 8'hc3);
    i_cpu_model.load_compare(3'd3, 16'hfe00);
    i_cpu_model.load_compare(3'd4, 16'hfc00);
    i_cpu_model.load_compare(3'd5, 16'h03ff);
    wr(8'he2, 8'hfe);
    wr(8'he3, 8'hff);
    wr(8'hbc, 8'h64);
    tick(2'b10, 1);
    check({5'h00, module_output_pin[5:3]}, 8'h07);
    tick(2'b10, 1);
    check({5'h00, module_output_pin[5:3]}, 8'h02);
    rd_chk(8'he2, 8'h00);
    rd_chk(8'he3, 8'hfc);
    rd_chk(8'ha5, 8'h80);
    check({7'h00, counter_irq}, 8'h01);
    wr(8'ha5, 8'h00);
    check({7'h00, counter_irq}, 8'h00);
    wr(8'hc3, 8'hcb);
    wr(8'he2, 8'hff);
    wr(8'he3, 8'hfd);
    tick(2'b10, 1);
    check({5'h00, module_output_pin[5:3]}, 8'h03);
    rd_chk(8'ha5, 8'h10);
    check({7'h00, counter_irq}, 8'h01);
    wr(8'ha5, 8'h00);
    check({7'h00, counter_irq}, 8'h00);
    $display("10-bit modulation done");
    print_verdict;
  end
endmodule
bind counter_array_pwm_10_16bit counter_array_pwm_checker i_checker (.ref_clk(ref_clk), .reset(reset),
  .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
  .cpu_idle(cpu_idle), .prescaler_tick(prescaler_tick), .timer0_overflow(timer0_overflow),
  .external_clock_pin(external_clock_pin), .module_output_pin(module_output_pin),
  .module_output_enable(module_output_enable), .counter_irq(counter_irq));
